/* File: bench/dsp_core_model.sv */
// core side model: enters a posted interrupt after a chosen delay
`timescale 1ns/100ps
module dsp_core_model (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        irqReq,
    input  wire logic [15:0] irqVector,
    input  wire logic  [3:0] ackDelay,
    output logic             irqAck,
    output logic      [15:0] takenVector
);
    typedef struct packed {
        logic        ack;
        logic  [3:0] cnt;
        logic [15:0] taken;
    } core_state_t;
    core_state_t state_reg;
    core_state_t state_next;

    // ack only a standing request, one pulse, so entry is never counted twice
    always_comb begin
        state_next = state_reg;
        state_next.ack = 1'b0;
        state_next.cnt = 4'h0;
        if (irqReq && !state_reg.ack) begin
            if (state_reg.cnt == ackDelay) begin
                state_next.ack = 1'b1;
                state_next.taken = irqVector;
            end else begin
                state_next.cnt = state_reg.cnt + 4'h1;
            end
        end
    end

    // state register
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end
    assign irqAck = state_reg.ack;
    assign takenVector = state_reg.taken;
endmodule

/* File: bench/dsp_irq_io_regs_monitor.sv */
// assertion checker for the dsp interrupt and i/o register block
`timescale 1ns/100ps
module dsp_irq_io_regs_monitor (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] memAddr,
    input  wire logic        memSpaceY,
    input  wire logic        memWr,
    input  wire logic        memRd,
    input  wire logic [15:0] memWrData,
    input  wire logic        memRdValid,
    input  wire logic        irqReq,
    input  wire logic [15:0] irqVector,
    input  wire logic        irqAck,
    input  wire logic [15:0] rightSample,
    input  wire logic        sampleStrobe,
    input  wire logic        sciSel,
    input  wire logic        sciRd,
    input  wire logic  [7:0] sciAddr
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    // an x-space access is taken at this edge
    logic xAcc;
    assign xAcc = (memWr || memRd) && !memSpaceY;

    property p_reset;
        $rose(nrst) |-> !irqReq && !memRdValid && !sampleStrobe;
    endproperty
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
    property p_depthRd;
        xAcc && memRd && !memWr && memAddr == dsp_irq_pkg::DEPTH_ADDR |=> memRdValid;
    endproperty
    a_depthRd: assert property (p_depthRd) else $error("counter read not answered");
    property p_sciRd;
        xAcc && memRd && !memWr && memAddr[15:8] == 8'h40
            |=> sciSel && sciRd && sciAddr == $past(memAddr[7:0]) ##1 memRdValid;
    endproperty
    a_sciRd: assert property (p_sciRd) else $error("window read not forwarded");
    property p_yIgnored;
        (memWr || memRd) && memSpaceY |=> !sciSel && !sampleStrobe;
    endproperty
    a_yIgnored: assert property (p_yIgnored) else $error("y access decoded");
    property p_strobe;
        xAcc && memWr && memAddr == dsp_irq_pkg::RIGHT_ADDR
            |=> sampleStrobe && rightSample == $past(memWrData);
    endproperty
    a_strobe: assert property (p_strobe) else $error("right sample not taken");
    property p_vector;
        irqReq |-> irqVector == 16'h4000 || irqVector == 16'h4002 || irqVector == 16'h4004;
    endproperty
    a_vector: assert property (p_vector) else $error("vector outside the slots");
    property p_ackBlocks;
        irqReq && irqAck |=> !irqReq [*2];
    endproperty
    a_ackBlocks: assert property (p_ackBlocks) else $error("request kept after entry");
    property p_incMasks;
        xAcc && memWr && memAddr == dsp_irq_pkg::MASK_INC_ADDR |-> ##[1:6] !irqReq;
    endproperty
    a_incMasks: assert property (p_incMasks) else $error("request not masked");
    property p_reqHolds;
        irqReq && !irqAck && !memWr && !$past(memWr) |=> irqReq && $stable(irqVector);
    endproperty
    a_reqHolds: assert property (p_reqHolds) else $error("request dropped unasked");

    // main scenarios reached
    c_entry: cover property (irqReq && irqAck);
    c_sci: cover property (sciRd);
    c_strobe: cover property (sampleStrobe);
endmodule

/* File: bench/tb_dsp_irq_io_regs.sv */
// self-checking bench for the dsp interrupt and i/o register block
`timescale 1ns/100ps
module tb_dsp_irq_io_regs;
    logic        core_clk, nrst, memSpaceY, memWr, memRd, memRdValid, irqReq, irqAck;
    logic        audioEvent, commandEvent, streamEvent, rxWordValid, dataRequest;
    logic        sampleStrobe, sciSel, sciWr, sciRd, ok;
    logic [15:0] memAddr, memWrData, memRdData, irqVector, rxWordIn, leftSample;
    logic [15:0] rightSample, sciWrData, sciRdData, takenVector, got;
    logic  [7:0] sciAddr;
    logic  [3:0] ackDelay;
    int          n_mismatch = 0;
    int          checks_done = 0;
    typedef struct {logic wr; logic [15:0] a; logic [15:0] d; logic [15:0] e;} row_t;
    row_t rows [0:13] = '{'{1, 16'h4300, 16'h0007, 0}, '{0, 16'h4300, 0, 16'h0007},
        '{1, 16'h4301, 0, 0}, '{0, 16'h4303, 0, 16'h0001}, '{1, 16'h4301, 16'hffff, 0},
        '{0, 16'h4303, 0, 16'h0002}, '{1, 16'h4302, 0, 0}, '{0, 16'h4303, 0, 16'h0001},
        '{1, 16'h4303, 16'h5555, 0}, '{0, 16'h4303, 0, 16'h0001}, '{1, 16'h4302, 0, 0},
        '{0, 16'h4303, 0, 16'h0000}, '{0, 16'h4202, 0, 16'h0000}, '{0, 16'h4101, 0, 16'h0001}};

    dsp_irq_io_regs dsp_irq_io_regs_inst (.core_clk(core_clk), .nrst(nrst), .memAddr(memAddr),
        .memSpaceY(memSpaceY), .memWr(memWr), .memRd(memRd), .memWrData(memWrData),
        .memRdData(memRdData), .memRdValid(memRdValid), .irqReq(irqReq),
        .irqVector(irqVector), .irqAck(irqAck), .audioEvent(audioEvent),
        .commandEvent(commandEvent), .streamEvent(streamEvent), .rxWordValid(rxWordValid),
        .rxWordIn(rxWordIn), .dataRequest(dataRequest), .leftSample(leftSample),
        .rightSample(rightSample), .sampleStrobe(sampleStrobe), .sciSel(sciSel),
        .sciWr(sciWr), .sciRd(sciRd), .sciAddr(sciAddr), .sciWrData(sciWrData),
        .sciRdData(sciRdData));
    dsp_core_model dsp_core_model_inst (.core_clk(core_clk), .nrst(nrst), .irqReq(irqReq),
        .irqVector(irqVector), .ackDelay(ackDelay), .irqAck(irqAck),
        .takenVector(takenVector));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one write, strobe held for a single taking edge
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic y = 1'b0);
        @(posedge core_clk);
        memWr <= 1'b1;
        memAddr <= a;
        memWrData <= d;
        memSpaceY <= y;
        @(posedge core_clk);
        memWr <= 1'b0;
        memSpaceY <= 1'b0;
    endtask
    // one read; the idle cycles after it keep a window answer from colliding
    task automatic rd(input logic [15:0] a, output logic [15:0] d, output logic v);
        @(posedge core_clk);
        memRd <= 1'b1;
        memAddr <= a;
        @(posedge core_clk);
        memRd <= 1'b0;
        v = 1'b0;
        d = 16'h0000;
        repeat (3) begin
            @(negedge core_clk);
            if (memRdValid === 1'b1 && !v) begin
                v = 1'b1;
                d = memRdData;
            end
        end
    endtask
    task automatic ev(input logic [2:0] s);
        @(posedge core_clk);
        {streamEvent, commandEvent, audioEvent} <= s;
        @(posedge core_clk);
        {streamEvent, commandEvent, audioEvent} <= 3'h0;
    endtask
    // wait for a request, let the core enter, then end the handler
    task automatic serve(input logic [15:0] vec);
        int n;
        n = 0;
        while (irqReq !== 1'b1 && n < 12) begin
            @(negedge core_clk);
            n++;
        end
        check("irqVector", irqVector, vec);
        n = 0;
        while (irqReq !== 1'b0 && n < 20) begin
            @(negedge core_clk);
            n++;
        end
        check("takenVector", takenVector, vec);
        rd(dsp_irq_pkg::DEPTH_ADDR, got, ok);
        check("depth in handler", got, 16'h0001);
        wr(dsp_irq_pkg::MASK_DEC_ADDR, 16'h0000);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // cut a hang short well past the expected few hundred cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        {nrst, memSpaceY, memWr, memRd, audioEvent, commandEvent, streamEvent} = '0;
        {memAddr, memWrData, rxWordIn, rxWordValid, ackDelay} = '0;
        dataRequest = 1'b1;
        sciRdData = 16'hc3a5;
        repeat (10) @(posedge core_clk);
        nrst <= 1'b1;
        rd(dsp_irq_pkg::SRC_MASK_ADDR, got, ok);
        check("mask after reset", got, 16'h0000);
        rd(dsp_irq_pkg::DEPTH_ADDR, got, ok);
        check("depth after reset", got, 16'h0000);
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end else begin
                rd(rows[i].a, got, ok);
                check("table read", got, rows[i].e);
            end
        end
        // three sources at once, core entering promptly then slowly
        ev(3'h7);
        for (int i = 0; i < 3; i++) begin
            ackDelay <= 4'(3 * i);
            serve(16'h4000 + 16'(2 * i));
        end
        wr(dsp_irq_pkg::SRC_MASK_ADDR, 16'h0006);
        ev(3'h1);
        repeat (10) @(posedge core_clk);
        check("masked audio", {15'h0000, irqReq}, 16'h0000);
        wr(dsp_irq_pkg::SRC_MASK_ADDR, 16'h0001);
        serve(dsp_irq_pkg::AUDIO_VECTOR_SLOT);
        wr(dsp_irq_pkg::SRC_MASK_ADDR, 16'h0007);
        wr(dsp_irq_pkg::MASK_INC_ADDR, 16'h1234);
        ev(3'h2);
        repeat (10) @(posedge core_clk);
        check("nested mask", {15'h0000, irqReq}, 16'h0000);
        wr(dsp_irq_pkg::MASK_DEC_ADDR, 16'h0000);
        serve(dsp_irq_pkg::COMMAND_VECTOR_SLOT);
        wr(dsp_irq_pkg::SRC_MASK_ADDR, 16'h0000, 1'b1);
        rd(dsp_irq_pkg::SRC_MASK_ADDR, got, ok);
        check("mask after y write", got, 16'h0007);
        @(posedge core_clk);
        rxWordValid <= 1'b1;
        rxWordIn <= 16'h1234;
        @(posedge core_clk);
        rxWordIn <= 16'hbeef;
        @(posedge core_clk);
        rxWordValid <= 1'b0;
        rd(dsp_irq_pkg::RX_WORD_ADDR, got, ok);
        check("rx word", got, 16'hbeef);
        rd(16'h4012, got, ok);
        check("window read", got, 16'hc3a5);
        check("window addr", {8'h00, sciAddr}, 16'h0012);
        dataRequest <= 1'b0;
        rd(dsp_irq_pkg::REQ_FLAG_ADDR, got, ok);
        check("request flag", got, 16'h0000);
        wr(dsp_irq_pkg::LEFT_ADDR, 16'h8001);
        wr(dsp_irq_pkg::RIGHT_ADDR, 16'h7ffe);
        @(negedge core_clk);
        check("left sample", leftSample, 16'h8001);
        check("right sample", rightSample, 16'h7ffe);
        check("sample strobe", {15'h0000, sampleStrobe}, 16'h0001);
        rd(16'h4400, got, ok);
        check("unmapped answer", {15'h0000, ok}, 16'h0000);
        // a window write is forwarded with its strobe, low address byte and data
        wr(16'h4005, 16'h5a5a);
        @(negedge core_clk);
        check("window write", {sciWr, 7'h00, sciAddr}, 16'h8005);
        check("window data", sciWrData, 16'h5a5a);
        // reset in mid-run, with the mask set and the counter raised
        wr(dsp_irq_pkg::MASK_INC_ADDR, 16'h0000);
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (3) @(posedge core_clk);
        nrst <= 1'b1;
        rd(dsp_irq_pkg::DEPTH_ADDR, got, ok);
        check("depth after mid reset", got, 16'h0000);
        rd(dsp_irq_pkg::SRC_MASK_ADDR, got, ok);
        check("mask after mid reset", got, 16'h0000);
        end_of_test();
    end
endmodule

bind dsp_irq_io_regs dsp_irq_io_regs_monitor dsp_irq_io_regs_monitor_inst (
    .core_clk(core_clk), .nrst(nrst), .memAddr(memAddr), .memSpaceY(memSpaceY),
    .memWr(memWr), .memRd(memRd), .memWrData(memWrData), .memRdValid(memRdValid),
    .irqReq(irqReq), .irqVector(irqVector), .irqAck(irqAck), .rightSample(rightSample),
    .sampleStrobe(sampleStrobe), .sciSel(sciSel), .sciRd(sciRd), .sciAddr(sciAddr));

/* File: hw/dsp_irq_io_regs.sv */
// interrupt mask, nesting counter and serial/audio i/o registers of the dsp core
`timescale 1ns/100ps

// Behaviour
// - enable register bit 0 permits the audio output interrupt when set.
// - enable bit 1 gates command port interrupt, bit 2 gates serial data.
// - an enable write reaches interrupt delivery within six core cycles.
// - any write to the mask-increment register adds one to the nesting counter unless it is already at its maximum.
// - any write to the mask-decrement register subtracts one from the counter unless it is already zero.
// - with the counter at zero, enabled pending sources are delivered again.
// - taking an interrupt adds one to the nesting counter automatically.
// - mask-increment and decrement writes take effect within six core cycles.
// - the counter reads back at its address; nonzero means all blocked.
// - serial capture register returns the latest word from the data input.
// - bit 0 of the request status register shows the data request pin.
// - the command port registers occupy the x range from its base upward.
// - all hardware registers decode in x data space only, never y.
// - interrupt entry vectors to fixed two-word slots per source.
module dsp_irq_io_regs (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    // core data bus
    input  wire logic [15:0] memAddr,
    input  wire logic        memSpaceY,
    input  wire logic        memWr,
    input  wire logic        memRd,
    input  wire logic [15:0] memWrData,
    output logic      [15:0] memRdData,
    output logic             memRdValid,
    // interrupt entry handshake with the core
    output logic             irqReq,
    output logic      [15:0] irqVector,
    input  wire logic        irqAck,
    // event sources, one-cycle pulses
    input  wire logic        audioEvent,
    input  wire logic        commandEvent,
    input  wire logic        streamEvent,
    // serial data input side
    input  wire logic        rxWordValid,
    input  wire logic [15:0] rxWordIn,
    input  wire logic        dataRequest,
    // audio output side
    output logic      [15:0] leftSample,
    output logic      [15:0] rightSample,
    output logic             sampleStrobe,
    // serial command port register window
    output logic             sciSel,
    output logic             sciWr,
    output logic             sciRd,
    output logic       [7:0] sciAddr,
    output logic      [15:0] sciWrData,
    input  wire logic [15:0] sciRdData
);

    dsp_irq_pkg::state_t s_reg;
    dsp_irq_pkg::state_t s_next;

    // exact x-space match against one register offset
    function automatic logic xHit(input logic [15:0] addr, input logic isY,
                                  input logic [15:0] target);
        xHit = !isY && (addr == target);
    endfunction

    // x-space match against the command port window
    function automatic logic sciHit(input logic [15:0] addr, input logic isY);
        sciHit = !isY && (addr >= dsp_irq_pkg::SCI_BASE)
                      && (addr <= dsp_irq_pkg::SCI_LAST);
    endfunction

    // fixed-priority pick among enabled pending sources, lowest bit first
    function automatic logic [2:0] pickSource(input logic [2:0] req);
        pickSource = 3'h0;
        if (req[dsp_irq_pkg::SRC_AUDIO]) begin
            pickSource[dsp_irq_pkg::SRC_AUDIO] = 1'b1;
        end else if (req[dsp_irq_pkg::SRC_COMMAND]) begin
            pickSource[dsp_irq_pkg::SRC_COMMAND] = 1'b1;
        end else if (req[dsp_irq_pkg::SRC_STREAM]) begin
            pickSource[dsp_irq_pkg::SRC_STREAM] = 1'b1;
        end
    endfunction

    // vector slot for a one-hot granted source
    function automatic logic [15:0] slotOf(input logic [2:0] grant);
        if (grant[dsp_irq_pkg::SRC_AUDIO]) begin
            slotOf = dsp_irq_pkg::AUDIO_VECTOR_SLOT;
        end else if (grant[dsp_irq_pkg::SRC_COMMAND]) begin
            slotOf = dsp_irq_pkg::COMMAND_VECTOR_SLOT;
        end else begin
            slotOf = dsp_irq_pkg::STREAM_VECTOR_SLOT;
        end
    endfunction

    logic [2:0]  eventIn;
    logic        wrInc;
    logic        wrDec;
    logic        ackTaken;
    logic [2:0]  armed;
    logic [2:0]  grant;
    logic [16:0] depthSum;

    // next-state logic for the whole block
    always_comb begin
        s_next = s_reg;
        eventIn = {streamEvent, commandEvent, audioEvent};
        s_next.sampleStrobe = 1'b0;
        s_next.rdValid = 1'b0;
        s_next.sciWr = 1'b0;
        s_next.sciRd = 1'b0;
        s_next.sciSel = 1'b0;
        s_next.sciRdPend = 1'b0;

        wrInc = memWr && xHit(memAddr, memSpaceY, dsp_irq_pkg::MASK_INC_ADDR);
        wrDec = memWr && xHit(memAddr, memSpaceY, dsp_irq_pkg::MASK_DEC_ADDR);
        ackTaken = irqAck && (s_reg.irqState == dsp_irq_pkg::IRQ_POSTED);

        // enable register write, effective on the next edge, well inside six cycles
        if (memWr && xHit(memAddr, memSpaceY, dsp_irq_pkg::SRC_MASK_ADDR)) begin
            s_next.srcMask = memWrData[2:0];
        end

        // nesting counter: increments from software and from entry, one decrement
        depthSum = {1'b0, s_reg.depth};
        if (wrInc) begin
            depthSum = depthSum + {1'b0, dsp_irq_pkg::DEPTH_ONE};
        end
        if (ackTaken) begin
            depthSum = depthSum + {1'b0, dsp_irq_pkg::DEPTH_ONE};
        end
        if (wrDec && depthSum != {1'b0, dsp_irq_pkg::DEPTH_RESET}) begin
            depthSum = depthSum - {1'b0, dsp_irq_pkg::DEPTH_ONE};
        end
        // saturate rather than wrap, so a runaway handler cannot unmask everything
        if (depthSum > {1'b0, dsp_irq_pkg::DEPTH_MAX}) begin
            s_next.depth = dsp_irq_pkg::DEPTH_MAX;
        end else begin
            s_next.depth = depthSum[15:0];
        end

        // pending flags: a new event wins over the clear from an entry
        s_next.pending = s_reg.pending;
        if (ackTaken) begin
            s_next.pending = s_next.pending & ~s_reg.irqGrant;
        end
        s_next.pending = s_next.pending | eventIn;

        // delivery: only with counter at zero and source enabled
        armed = s_reg.pending & s_reg.srcMask;
        grant = pickSource(armed);
        case (s_reg.irqState)
            dsp_irq_pkg::IRQ_IDLE: begin
                if (s_reg.depth == dsp_irq_pkg::DEPTH_RESET && armed != 3'h0) begin
                    s_next.irqState = dsp_irq_pkg::IRQ_POSTED;
                    s_next.irqReq = 1'b1;
                    s_next.irqGrant = grant;
                    s_next.irqVector = slotOf(grant);
                end
            end
            dsp_irq_pkg::IRQ_POSTED: begin
                // withdraw if entry happened or masking changed under the request
                if (ackTaken || s_reg.depth != dsp_irq_pkg::DEPTH_RESET
                    || (s_reg.irqGrant & armed) == 3'h0) begin
                    s_next.irqState = dsp_irq_pkg::IRQ_IDLE;
                    s_next.irqReq = 1'b0;
                end
            end
            default: begin
                s_next.irqState = dsp_irq_pkg::IRQ_IDLE;
                s_next.irqReq = 1'b0;
            end
        endcase

        // serial capture keeps the latest received word
        if (rxWordValid) begin
            s_next.rxWord = rxWordIn;
        end

        // sample registers; the strobe marks a completed stereo pair
        if (memWr && xHit(memAddr, memSpaceY, dsp_irq_pkg::LEFT_ADDR)) begin
            s_next.leftSample = memWrData;
        end
        if (memWr && xHit(memAddr, memSpaceY, dsp_irq_pkg::RIGHT_ADDR)) begin
            s_next.rightSample = memWrData;
            s_next.sampleStrobe = 1'b1;
        end

        // command port window is forwarded, not held here
        if ((memWr || memRd) && sciHit(memAddr, memSpaceY)) begin
            s_next.sciSel = 1'b1;
            s_next.sciWr = memWr;
            s_next.sciRd = memRd && !memWr;
            s_next.sciAddr = memAddr[7:0];
            s_next.sciWrData = memWrData;
            s_next.sciRdPend = memRd && !memWr;
        end

        // local reads answer next cycle; window reads one cycle later
        if (s_reg.sciRdPend) begin
            s_next.rdData = sciRdData;
            s_next.rdValid = 1'b1;
        end else if (memRd && !memWr && !memSpaceY) begin
            if (memAddr == dsp_irq_pkg::RX_WORD_ADDR) begin
                s_next.rdData = s_reg.rxWord;
                s_next.rdValid = 1'b1;
            end else if (memAddr == dsp_irq_pkg::REQ_FLAG_ADDR) begin
                s_next.rdData = dsp_irq_pkg::ZERO_WORD;
                s_next.rdData[dsp_irq_pkg::REQ_FLAG_BIT] = dataRequest;
                s_next.rdValid = 1'b1;
            end else if (memAddr == dsp_irq_pkg::SRC_MASK_ADDR) begin
                s_next.rdData = {13'h0000, s_reg.srcMask};
                s_next.rdValid = 1'b1;
            end else if (memAddr == dsp_irq_pkg::DEPTH_ADDR) begin
                s_next.rdData = s_reg.depth;
                s_next.rdValid = 1'b1;
            end else if (memAddr == dsp_irq_pkg::LEFT_ADDR
                         || memAddr == dsp_irq_pkg::RIGHT_ADDR
                         || memAddr == dsp_irq_pkg::FILTER_ADDR
                         || memAddr == dsp_irq_pkg::MASK_INC_ADDR
                         || memAddr == dsp_irq_pkg::MASK_DEC_ADDR) begin
                // write-only and reserved words read as zero
                s_next.rdData = dsp_irq_pkg::ZERO_WORD;
                s_next.rdValid = 1'b1;
            end
        end
    end

    // state register; counter and enables clear on reset
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            s_reg.srcMask <= dsp_irq_pkg::SRC_MASK_RESET;
            s_reg.depth <= dsp_irq_pkg::DEPTH_RESET;
            s_reg.pending <= 3'h0;
            s_reg.rxWord <= dsp_irq_pkg::ZERO_WORD;
            s_reg.leftSample <= dsp_irq_pkg::ZERO_WORD;
            s_reg.rightSample <= dsp_irq_pkg::ZERO_WORD;
            s_reg.sampleStrobe <= 1'b0;
            s_reg.rdData <= dsp_irq_pkg::ZERO_WORD;
            s_reg.rdValid <= 1'b0;
            s_reg.sciSel <= 1'b0;
            s_reg.sciWr <= 1'b0;
            s_reg.sciRd <= 1'b0;
            s_reg.sciAddr <= dsp_irq_pkg::ZERO_SCI;
            s_reg.sciWrData <= dsp_irq_pkg::ZERO_WORD;
            s_reg.sciRdPend <= 1'b0;
            s_reg.irqState <= dsp_irq_pkg::IRQ_IDLE;
            s_reg.irqReq <= 1'b0;
            s_reg.irqVector <= dsp_irq_pkg::ZERO_WORD;
            s_reg.irqGrant <= 3'h0;
        end else begin
            s_reg <= s_next;
        end
    end

    // every output is a field of the state register
    assign memRdData    = s_reg.rdData;
    assign memRdValid   = s_reg.rdValid;
    assign irqReq       = s_reg.irqReq;
    assign irqVector    = s_reg.irqVector;
    assign leftSample   = s_reg.leftSample;
    assign rightSample  = s_reg.rightSample;
    assign sampleStrobe = s_reg.sampleStrobe;
    assign sciSel       = s_reg.sciSel;
    assign sciWr        = s_reg.sciWr;
    assign sciRd        = s_reg.sciRd;
    assign sciAddr      = s_reg.sciAddr;
    assign sciWrData    = s_reg.sciWrData;

endmodule

/* File: hw/dsp_irq_pkg.sv */
// constants and types shared by the dsp interrupt and i/o register block
package dsp_irq_pkg;

    // data path widths
    localparam int DATA_W  = 16;
    localparam int ADDR_W  = 16;
    localparam int SCI_W   = 8;
    localparam int NUM_SRC = 3;

    // x-space register map
    localparam logic [15:0] SCI_BASE      = 16'h4000;
    localparam logic [15:0] SCI_LAST      = 16'h40ff;
    localparam logic [15:0] RX_WORD_ADDR  = 16'h4100;
    localparam logic [15:0] REQ_FLAG_ADDR = 16'h4101;
    localparam logic [15:0] LEFT_ADDR     = 16'h4200;
    localparam logic [15:0] RIGHT_ADDR    = 16'h4201;
    localparam logic [15:0] FILTER_ADDR   = 16'h4202;
    localparam logic [15:0] SRC_MASK_ADDR = 16'h4300;
    localparam logic [15:0] MASK_INC_ADDR = 16'h4301;
    localparam logic [15:0] MASK_DEC_ADDR = 16'h4302;
    localparam logic [15:0] DEPTH_ADDR    = 16'h4303;

    // source bit positions in the enable and pending fields
    localparam int SRC_AUDIO   = 0;
    localparam int SRC_COMMAND = 1;
    localparam int SRC_STREAM  = 2;

    // request flag position in its status word
    localparam int REQ_FLAG_BIT = 0;

    // two-word vector slots, one per source
    localparam logic [15:0] AUDIO_VECTOR_SLOT   = 16'h4000;
    localparam logic [15:0] COMMAND_VECTOR_SLOT = 16'h4002;
    localparam logic [15:0] STREAM_VECTOR_SLOT  = 16'h4004;

    // reset values and counter limits
    localparam logic [NUM_SRC-1:0] SRC_MASK_RESET = 3'h0;
    localparam logic [15:0]        DEPTH_RESET    = 16'h0000;
    localparam logic [15:0]        DEPTH_MAX      = 16'hffff;
    localparam logic [15:0]        DEPTH_ONE      = 16'h0001;
    localparam logic [15:0]        ZERO_WORD      = 16'h0000;
    localparam logic [SCI_W-1:0]   ZERO_SCI       = 8'h00;

    // longest allowed delay from a mask write to its effect, in core cycles
    localparam int EFFECT_DELAY_MAX = 6;

    // interrupt delivery state
    typedef enum logic {
        IRQ_IDLE,
        IRQ_POSTED
    } irq_state_t;

    // complete register state of the block
    typedef struct packed {
        logic [NUM_SRC-1:0] srcMask;
        logic [15:0]        depth;
        logic [NUM_SRC-1:0] pending;
        logic [15:0]        rxWord;
        logic [15:0]        leftSample;
        logic [15:0]        rightSample;
        logic               sampleStrobe;
        logic [15:0]        rdData;
        logic               rdValid;
        logic               sciSel;
        logic               sciWr;
        logic               sciRd;
        logic [SCI_W-1:0]   sciAddr;
        logic [15:0]        sciWrData;
        logic               sciRdPend;
        irq_state_t         irqState;
        logic               irqReq;
        logic [15:0]        irqVector;
        logic [NUM_SRC-1:0] irqGrant;
    } state_t;

endpackage
